// [sysopt_regs.sv]
// system option register bank behind an ahb-lite slave port
// assumes one master, single word transfers, and event inputs synchronous to hclk
//
// Chosen here: the register offsets and register access over AHB-Lite.
`include "sysopt_map.svh"
`timescale 1ns/1ps
module sysopt_regs
    import sysopt_pkg::*;
#(
    parameter int PERIOD_W = 20
) (
    // clock and resets
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic por_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // option fields
    output logic watchdog_enable,
    output logic watchdog_clock_select,
    output logic stop_instruction_enable,
    output logic radio_enable,
    output logic temp_restart_enable,
    output logic temp_restart_level,
    output logic debug_pin_enable,
    output sysopt_wdt_code_t watchdog_timeout_select,
    output logic timer_ch0_clock_select,
    output logic timer_ch0_clock_divider,
    output sysopt_bus_sel_t bus_clock_select,
    // clock plan
    output logic [PERIOD_W-1:0] watchdog_period,
    output sysopt_khz_t high_freq_oscillator_khz,
    output sysopt_khz_t bus_clock_khz,
    // debug pin sharing
    input wire logic port_a_bit_four_data,
    output logic port_a_bit_four_out,
    output logic port_a_bit_four_oe,
    // timer channel 0 clocking
    input wire logic port_a_bit_two_in,
    input wire logic low_freq_oscillator_in,
    input wire logic radio_clk_src,
    output logic timer_ch0_clk_src,
    output logic timer_ch0_div_clk,
    // system events
    input wire logic stop_exec,
    input wire logic watchdog_expired,
    input wire logic temp_return_low,
    input wire logic temp_return_high,
    input wire logic in_deepest_stop,
    output logic stop_mode_entry,
    output logic illegal_opcode_reset,
    output logic watchdog_reset_req,
    output logic temp_restart_irq,
    output logic temp_restart_reset
);

    // word select from a byte address; used by write capture and read mux
    function automatic logic [1:0] sysopt_sel(input logic [31:0] addr);
        logic [1:0] sel;
        sel = 2'h0;
        if (addr[31:`SYSOPT_ADDR_BITS] == '0) begin
            sel[0] = addr[`SYSOPT_ADDR_BITS-1:0] == `SYSOPT_FIRST_OFFSET;
            sel[1] = addr[`SYSOPT_ADDR_BITS-1:0] == `SYSOPT_SECOND_OFFSET;
        end
        return sel;
    endfunction
    // oscillator frequency for a bus select code
    function automatic sysopt_khz_t sysopt_osc_khz(input sysopt_bus_sel_t sel);
        sysopt_khz_t khz;
        case (sel)
            2'h0: khz = `SYSOPT_OSC_KHZ_SEL0;
            2'h1: khz = `SYSOPT_OSC_KHZ_SEL1;
            2'h2: khz = `SYSOPT_OSC_KHZ_SEL2;
            default: khz = `SYSOPT_OSC_KHZ_SEL3;
        endcase
        return khz;
    endfunction
    // bus address phase capture
    logic [1:0] wsel_reg, wsel_next;
    logic [1:0] rsel;
    logic take;
    sysopt_byte_t wbyte;

    // write-once fields and their locks
    logic wdt_en_reg, wdt_en_next;
    logic wdt_clk_reg, wdt_clk_next;
    logic stop_en_reg, stop_en_next;
    sysopt_wdt_code_t wdt_to_reg, wdt_to_next;
    logic [3:0] lock_reg, lock_next;
    // freely writable fields
    logic radio_en_reg, radio_en_next;
    logic tr_en_reg, tr_en_next;
    logic tr_lvl_reg, tr_lvl_next;
    logic dbg_en_reg, dbg_en_next;
    logic tmr_sel_reg, tmr_sel_next;
    logic tmr_div_reg, tmr_div_next;
    sysopt_bus_sel_t bus_sel_reg, bus_sel_next;
    // read data
    logic [31:0] hrdata_reg, hrdata_next;
    sysopt_byte_t first_view, second_view;

    // zero wait state slave, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    // a transfer is taken on nonseq or seq with hready high
    assign take = hsel & htrans[1] & hready;
    assign rsel = (take & ~hwrite) ? sysopt_sel(haddr) : 2'h0;
    assign wbyte = hwdata[7:0];

    always_comb begin
        wsel_next = (take & hwrite) ? sysopt_sel(haddr) : 2'h0;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wsel_reg <= 2'h0;
        end else begin
            wsel_reg <= wsel_next;
        end
    end

    // each lock is set by the first write and only reset clears it; free fields take every write
    always_comb begin
        wdt_en_next = wdt_en_reg;
        wdt_clk_next = wdt_clk_reg;
        stop_en_next = stop_en_reg;
        wdt_to_next = wdt_to_reg;
        lock_next = lock_reg;
        radio_en_next = radio_en_reg;
        tr_en_next = tr_en_reg;
        tr_lvl_next = tr_lvl_reg;
        dbg_en_next = dbg_en_reg;
        tmr_sel_next = tmr_sel_reg;
        tmr_div_next = tmr_div_reg;
        bus_sel_next = bus_sel_reg;
        if (wsel_reg[0]) begin
            if (!lock_reg[0]) begin
                wdt_en_next = wbyte[`SYSOPT_WDT_EN_BIT];
            end
            if (!lock_reg[1]) begin
                wdt_clk_next = wbyte[`SYSOPT_WDT_CLK_BIT];
            end
            if (!lock_reg[2]) begin
                stop_en_next = wbyte[`SYSOPT_STOP_EN_BIT];
            end
            lock_next[2:0] = 3'h7;
            radio_en_next = wbyte[`SYSOPT_RADIO_EN_BIT];
            tr_en_next = wbyte[`SYSOPT_TR_EN_BIT];
            tr_lvl_next = wbyte[`SYSOPT_TR_LVL_BIT];
            dbg_en_next = wbyte[`SYSOPT_DBG_EN_BIT];
        end
        if (wsel_reg[1]) begin
            if (!lock_reg[3]) begin
                wdt_to_next = wbyte[`SYSOPT_WDT_TO_HI:`SYSOPT_WDT_TO_LO];
            end
            lock_next[3] = 1'b1;
            tmr_sel_next = wbyte[`SYSOPT_TMR_SEL_BIT];
            tmr_div_next = wbyte[`SYSOPT_TMR_DIV_BIT];
            bus_sel_next = wbyte[`SYSOPT_BUS_SEL_HI:`SYSOPT_BUS_SEL_LO];
        end
    end

    // mcu reset reloads every field but radio enable and reopens the locks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_en_reg <= `SYSOPT_WDT_EN_RST;
            wdt_clk_reg <= `SYSOPT_WDT_CLK_RST;
            stop_en_reg <= `SYSOPT_STOP_EN_RST;
            wdt_to_reg <= `SYSOPT_WDT_TO_RST;
            lock_reg <= 4'h0;
            tr_en_reg <= `SYSOPT_TR_RST;
            tr_lvl_reg <= `SYSOPT_TR_RST;
            dbg_en_reg <= `SYSOPT_DBG_EN_RST;
            tmr_sel_reg <= `SYSOPT_TMR_RST;
            tmr_div_reg <= `SYSOPT_TMR_RST;
            bus_sel_reg <= `SYSOPT_BUS_SEL_RST;
        end else begin
            wdt_en_reg <= wdt_en_next;
            wdt_clk_reg <= wdt_clk_next;
            stop_en_reg <= stop_en_next;
            wdt_to_reg <= wdt_to_next;
            lock_reg <= lock_next;
            tr_en_reg <= tr_en_next;
            tr_lvl_reg <= tr_lvl_next;
            dbg_en_reg <= dbg_en_next;
            tmr_sel_reg <= tmr_sel_next;
            tmr_div_reg <= tmr_div_next;
            bus_sel_reg <= bus_sel_next;
        end
    end

    // radio enable sits on the power-up reset alone so it survives mcu resets and stop exits
    always_ff @(posedge hclk or negedge por_n) begin
        if (!por_n) begin
            radio_en_reg <= `SYSOPT_RADIO_EN_RST;
        end else begin
            radio_en_reg <= radio_en_next;
        end
    end

    // read views are built from the next values so a read right after a write sees it
    always_comb begin
        first_view = 8'h00;
        first_view[`SYSOPT_WDT_EN_BIT] = wdt_en_next;
        first_view[`SYSOPT_WDT_CLK_BIT] = wdt_clk_next;
        first_view[`SYSOPT_STOP_EN_BIT] = stop_en_next;
        first_view[`SYSOPT_RADIO_EN_BIT] = radio_en_next;
        first_view[`SYSOPT_TR_EN_BIT] = tr_en_next;
        first_view[`SYSOPT_TR_LVL_BIT] = tr_lvl_next;
        first_view[`SYSOPT_DBG_EN_BIT] = dbg_en_next;
        first_view[`SYSOPT_RSVD_ONE_BIT] = `SYSOPT_RSVD_ONE;
        second_view = 8'h00;
        second_view[`SYSOPT_UNUSED_BIT] = `SYSOPT_UNUSED_ZERO;
        second_view[`SYSOPT_WDT_TO_HI:`SYSOPT_WDT_TO_LO] = wdt_to_next;
        second_view[`SYSOPT_TMR_SEL_BIT] = tmr_sel_next;
        second_view[`SYSOPT_TMR_DIV_BIT] = tmr_div_next;
        second_view[`SYSOPT_BUS_SEL_HI:`SYSOPT_BUS_SEL_LO] = bus_sel_next;
        hrdata_next = hrdata_reg;
        if (take & ~hwrite) begin
            hrdata_next = 32'h0000_0000; // unmapped reads give zero
            if (rsel[0]) begin
                hrdata_next = {24'h00_0000, first_view};
            end
            if (rsel[1]) begin
                hrdata_next = {24'h00_0000, second_view};
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else begin
            hrdata_reg <= hrdata_next;
        end
    end

    assign hrdata = hrdata_reg;

    // field outputs straight from their flops
    assign watchdog_enable = wdt_en_reg;
    assign watchdog_clock_select = wdt_clk_reg;
    assign stop_instruction_enable = stop_en_reg;
    assign radio_enable = radio_en_reg;
    assign temp_restart_enable = tr_en_reg;
    assign temp_restart_level = tr_lvl_reg;
    assign debug_pin_enable = dbg_en_reg;
    assign watchdog_timeout_select = wdt_to_reg;
    assign timer_ch0_clock_select = tmr_sel_reg;
    assign timer_ch0_clock_divider = tmr_div_reg;
    assign bus_clock_select = bus_sel_reg;

    // period table lookup for the watchdog
    logic [PERIOD_W-1:0] period_raw;
    sysopt_timeout_decode #(
        .PERIOD_W(PERIOD_W)
    ) u_timeout_decode (
        .code(wdt_to_reg),
        .period(period_raw)
    );

    // registered clock plan, pin muxes, radio clock divider and system events
    logic [PERIOD_W-1:0] period_reg, period_next;
    sysopt_khz_t osc_reg, osc_next;
    sysopt_khz_t bus_reg, bus_next;
    logic pa4_out_reg, pa4_out_next;
    logic pa4_oe_reg, pa4_oe_next;
    logic tsrc_reg, tsrc_next;
    logic rc_prev_reg, rc_prev_next;
    logic [1:0] div_cnt_reg, div_cnt_next;
    logic div_q_reg, div_q_next;
    logic dclk_reg, dclk_next;
    logic stop_ok_reg, stop_ok_next;
    logic ilop_reg, ilop_next;
    logic wdr_reg, wdr_next;
    logic tirq_reg, tirq_next;
    logic trst_reg, trst_next;
    logic rc_edge;
    logic temp_hit;
    // the divider samples its source, which must stay well under half of hclk
    assign rc_edge = radio_clk_src & ~rc_prev_reg;
    // the level bit picks which return direction counts
    assign temp_hit = tr_en_reg & (tr_lvl_reg ? temp_return_high : temp_return_low);

    always_comb begin
        period_next = period_raw;
        osc_next = sysopt_osc_khz(bus_sel_reg);
        bus_next = {1'b0, osc_next[15:1]}; // bus clock is always half the oscillator
        pa4_oe_next = ~dbg_en_reg; // pin is output-only gpio when debug is off
        pa4_out_next = dbg_en_reg ? 1'b0 : port_a_bit_four_data;
        tsrc_next = tmr_sel_reg ? low_freq_oscillator_in : port_a_bit_two_in;
        rc_prev_next = radio_clk_src;
        div_cnt_next = div_cnt_reg;
        div_q_next = div_q_reg;
        if (rc_edge) begin
            div_cnt_next = 2'(div_cnt_reg + 2'h1);
            if (div_cnt_reg == `SYSOPT_DIV8_HALF) begin
                div_q_next = ~div_q_reg;
            end
        end
        dclk_next = tmr_div_reg ? div_q_reg : radio_clk_src; // divide by 8 or by 1
        // events are one-cycle pulses one edge after their cause
        stop_ok_next = stop_exec & stop_en_reg;
        ilop_next = stop_exec & ~stop_en_reg;
        wdr_next = watchdog_expired & wdt_en_reg;
        tirq_next = temp_hit & ~in_deepest_stop;
        trst_next = temp_hit & in_deepest_stop;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_reg <= '0;
            osc_reg <= `SYSOPT_OSC_KHZ_SEL0;
            bus_reg <= 16'(`SYSOPT_OSC_KHZ_SEL0 >> 1);
            pa4_out_reg <= 1'b0;
            pa4_oe_reg <= 1'b0;
            tsrc_reg <= 1'b0;
            rc_prev_reg <= 1'b0;
            div_cnt_reg <= 2'h0;
            div_q_reg <= 1'b0;
            dclk_reg <= 1'b0;
            stop_ok_reg <= 1'b0;
            ilop_reg <= 1'b0;
            wdr_reg <= 1'b0;
            tirq_reg <= 1'b0;
            trst_reg <= 1'b0;
        end else begin
            period_reg <= period_next;
            osc_reg <= osc_next;
            bus_reg <= bus_next;
            pa4_out_reg <= pa4_out_next;
            pa4_oe_reg <= pa4_oe_next;
            tsrc_reg <= tsrc_next;
            rc_prev_reg <= rc_prev_next;
            div_cnt_reg <= div_cnt_next;
            div_q_reg <= div_q_next;
            dclk_reg <= dclk_next;
            stop_ok_reg <= stop_ok_next;
            ilop_reg <= ilop_next;
            wdr_reg <= wdr_next;
            tirq_reg <= tirq_next;
            trst_reg <= trst_next;
        end
    end

    assign watchdog_period = period_reg;
    assign high_freq_oscillator_khz = osc_reg;
    assign bus_clock_khz = bus_reg;
    assign port_a_bit_four_out = pa4_out_reg;
    assign port_a_bit_four_oe = pa4_oe_reg;
    assign timer_ch0_clk_src = tsrc_reg;
    assign timer_ch0_div_clk = dclk_reg;
    assign stop_mode_entry = stop_ok_reg;
    assign illegal_opcode_reset = ilop_reg;
    assign watchdog_reset_req = wdr_reg;
    assign temp_restart_irq = tirq_reg;
    assign temp_restart_reset = trst_reg;
endmodule

// [sysopt_map.svh]
// offsets, fields and reset values of the option registers
// assumes each 8-bit register sits in the low byte of a bus word
//
// Overview of operation
// - watchdog, clock select, stop enable: first write only
// - watchdog enable bit 7, set by reset
// - bit 6 picks slow oscillator (0) or bus clock
// - bit 5 allows stop modes, cleared by reset
// - radio enable bit 4, power-up only, always writable
// - bit 3 enables temperature restart interrupt
// - bit 2 picks low or high return
// - bit 1 gives pin to debug, else gpio
// - first register bit 0 always reads one
// - second register bit 7 always reads zero
// - timeout field 6:4, longest code, write-once
// - bit 3 routes port pin or slow oscillator
// - bit 2 divides radio clock by 1 or 8
// - bus select codes give 4,2,1,0.5 mhz
// - bus clock is always fast oscillator over two
// - bus select cleared by reset, always writable
// - disabled stop instruction raises illegal-opcode reset
// - watchdog reset suppressed while enable is zero
// - temperature wakeup from deepest stop resets
`ifndef SYSOPT_MAP_SVH
`define SYSOPT_MAP_SVH

// register byte offsets
`define SYSOPT_FIRST_OFFSET 4'h0
`define SYSOPT_SECOND_OFFSET 4'h4
`define SYSOPT_ADDR_BITS 4

// first register fields
`define SYSOPT_WDT_EN_BIT 7
`define SYSOPT_WDT_CLK_BIT 6
`define SYSOPT_STOP_EN_BIT 5
`define SYSOPT_RADIO_EN_BIT 4
`define SYSOPT_TR_EN_BIT 3
`define SYSOPT_TR_LVL_BIT 2
`define SYSOPT_DBG_EN_BIT 1
`define SYSOPT_RSVD_ONE_BIT 0

// second register fields
`define SYSOPT_UNUSED_BIT 7
`define SYSOPT_WDT_TO_HI 6
`define SYSOPT_WDT_TO_LO 4
`define SYSOPT_TMR_SEL_BIT 3
`define SYSOPT_TMR_DIV_BIT 2
`define SYSOPT_BUS_SEL_HI 1
`define SYSOPT_BUS_SEL_LO 0

// reset values
`define SYSOPT_WDT_EN_RST 1'b1
`define SYSOPT_WDT_CLK_RST 1'b0
`define SYSOPT_STOP_EN_RST 1'b0
`define SYSOPT_RADIO_EN_RST 1'b0
`define SYSOPT_TR_RST 1'b0
`define SYSOPT_DBG_EN_RST 1'b1
`define SYSOPT_WDT_TO_RST 3'h7
`define SYSOPT_TMR_RST 1'b0
`define SYSOPT_BUS_SEL_RST 2'h0
`define SYSOPT_RSVD_ONE 1'b1
`define SYSOPT_UNUSED_ZERO 1'b0

// fast oscillator in khz per bus select; bus clock is half
`define SYSOPT_OSC_KHZ_SEL0 16'h1f40
`define SYSOPT_OSC_KHZ_SEL1 16'h0fa0
`define SYSOPT_OSC_KHZ_SEL2 16'h07d0
`define SYSOPT_OSC_KHZ_SEL3 16'h03e8

// radio clock divider: toggle every four source edges gives divide by eight
`define SYSOPT_DIV8_HALF 2'h3

`endif

// [sysopt_pkg.sv]
// types shared by the system option register bank
// assumes sysopt_map.svh supplies the numeric constants
package sysopt_pkg;
    typedef logic [2:0] sysopt_wdt_code_t;
    typedef logic [1:0] sysopt_bus_sel_t;
    typedef logic [7:0] sysopt_byte_t;
    typedef logic [15:0] sysopt_khz_t;
endpackage

// [sysopt_timeout_decode.sv]
// watchdog timeout decode: code to period length in watchdog clock ticks
// assumes the code is held stable by the register bank
`timescale 1ns/1ps
module sysopt_timeout_decode
    import sysopt_pkg::*;
#(
    parameter int PERIOD_W = 20
) (
    // code in
    input wire sysopt_wdt_code_t code,
    // period out
    output logic [PERIOD_W-1:0] period
);
    // table kept apart so a product can swap it; entries rise with the code,
    // so the reset code (all ones) is the longest period
    localparam logic [PERIOD_W-1:0] PERIOD_TABLE [8] = '{
        PERIOD_W'(32'h0000_0020), PERIOD_W'(32'h0000_0080),
        PERIOD_W'(32'h0000_0200), PERIOD_W'(32'h0000_0800),
        PERIOD_W'(32'h0000_2000), PERIOD_W'(32'h0000_8000),
        PERIOD_W'(32'h0002_0000), PERIOD_W'(32'h0008_0000)
    };

    // pure lookup, no storage
    always_comb begin
        period = PERIOD_TABLE[code];
    end
endmodule

// [sysopt_regs_asserts.sv]
// concurrent checks for the system option register bank
// sees only the bank's ports; bound into every sysopt_regs
`timescale 1ns/1ps
module sysopt_regs_asserts
    import sysopt_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    // option fields and clock plan
    input wire logic watchdog_enable,
    input wire logic stop_instruction_enable,
    input wire logic radio_enable,
    input wire logic temp_restart_enable,
    input wire logic temp_restart_level,
    input wire logic debug_pin_enable,
    input wire sysopt_bus_sel_t bus_clock_select,
    input wire sysopt_khz_t high_freq_oscillator_khz,
    input wire sysopt_khz_t bus_clock_khz,
    // shared pin and events
    input wire logic port_a_bit_four_data,
    input wire logic port_a_bit_four_out,
    input wire logic port_a_bit_four_oe,
    input wire logic stop_exec,
    input wire logic stop_mode_entry,
    input wire logic illegal_opcode_reset,
    input wire logic watchdog_expired,
    input wire logic watchdog_reset_req,
    input wire logic temp_return_low,
    input wire logic temp_return_high,
    input wire logic in_deepest_stop,
    input wire logic temp_restart_irq,
    input wire logic temp_restart_reset
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // address phases taken by the slave
    wire taken = hsel && htrans[1] && hready;
    wire wr_first = taken && hwrite && haddr == 32'h0;
    wire wr_second = taken && hwrite && haddr == 32'h4;
    wire rd_first = taken && !hwrite && haddr == 32'h0;
    wire rd_second = taken && !hwrite && haddr == 32'h4;

    // a first-register write since reset locks the next ones
    logic first_seen_reg;
    logic first_seen_next;
    always_comb begin
        first_seen_next = first_seen_reg | wr_first;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_seen_reg <= 1'b0;
        end else begin
            first_seen_reg <= first_seen_next;
        end
    end

    // writes land at the end of the data phase
    sequence s_locked_write;
        first_seen_reg && wr_first ##2 1'b1;
    endsequence
    sequence s_first_write;
        wr_first ##1 1'b1;
    endsequence
    sequence s_second_write;
        wr_second ##1 1'b1;
    endsequence

    a_lock_first: assert property (s_locked_write |-> $stable(watchdog_enable) && $stable(stop_instruction_enable))
        else $error("locked field changed");
    a_radio_free: assert property (s_first_write |=> radio_enable == $past(hwdata[4]))
        else $error("radio enable write lost");
    a_bus_free: assert property (s_second_write |=> bus_clock_select == $past(hwdata[1:0]))
        else $error("bus select write lost");
    a_first_bit0: assert property (rd_first |=> hrdata[0] == 1'b1)
        else $error("first bit 0 read zero");
    a_second_bit7: assert property (rd_second |=> hrdata[7] == 1'b0)
        else $error("second bit 7 read one");
    a_hfo_code: assert property ($stable(bus_clock_select) [*3] |-> high_freq_oscillator_khz == (16'h1f40 >> bus_clock_select))
        else $error("oscillator khz wrong");
    a_bus_half: assert property ($stable(bus_clock_select) [*3] |-> bus_clock_khz == (high_freq_oscillator_khz >> 1))
        else $error("bus khz not half");
    a_debug_pin: assert property (1'b1 |=> port_a_bit_four_oe == !$past(debug_pin_enable)
        && port_a_bit_four_out == ($past(port_a_bit_four_data) && !$past(debug_pin_enable)))
        else $error("shared pin drive wrong");
    a_stop_path: assert property (stop_exec |=> stop_mode_entry == $past(stop_instruction_enable)
        && illegal_opcode_reset == !$past(stop_instruction_enable))
        else $error("stop routed wrongly");
    a_wdt_gate: assert property (watchdog_expired |=> watchdog_reset_req == $past(watchdog_enable))
        else $error("watchdog reset ungated");
    a_temp_deep: assert property (temp_restart_enable && (temp_restart_level ? temp_return_high : temp_return_low)
        |=> temp_restart_reset == $past(in_deepest_stop) && temp_restart_irq == !$past(in_deepest_stop))
        else $error("temp restart wrong");
endmodule

bind sysopt_regs sysopt_regs_asserts u_asserts (.*);

// [system_option_registers_bench.sv]
// self-checking bench for the system option register bank
// assumes registered outputs one edge after their cause
`timescale 1ns/1ps
module system_option_registers_bench;
    import sysopt_pkg::*;
    localparam logic [31:0] ADDR_FIRST = 32'h0;
    localparam logic [31:0] ADDR_SECOND = 32'h4;
    logic hclk, hresetn, por_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic watchdog_enable, watchdog_clock_select, stop_instruction_enable, radio_enable;
    logic temp_restart_enable, temp_restart_level, debug_pin_enable, timer_ch0_clock_select, timer_ch0_clock_divider;
    sysopt_wdt_code_t watchdog_timeout_select;
    sysopt_bus_sel_t bus_clock_select;
    logic [19:0] watchdog_period;
    sysopt_khz_t high_freq_oscillator_khz, bus_clock_khz;
    logic port_a_bit_four_data, port_a_bit_four_out, port_a_bit_four_oe;
    logic port_a_bit_two_in, low_freq_oscillator_in, radio_clk_src, timer_ch0_clk_src, timer_ch0_div_clk;
    logic stop_exec, watchdog_expired, temp_return_low, temp_return_high, in_deepest_stop;
    logic stop_mode_entry, illegal_opcode_reset, watchdog_reset_req, temp_restart_irq, temp_restart_reset;
    int mismatches, checks_done;
    wire [4:0] events = {stop_mode_entry, illegal_opcode_reset, watchdog_reset_req, temp_restart_irq, temp_restart_reset};

    // one slave drives the bus ready
    assign hready = hreadyout;

    sysopt_regs #(.PERIOD_W(20)) DUT (.*);

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bounded wait for ready; a hang counts as a mismatch
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 40);
        if (hreadyout !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
    endtask

    // single transfer; read data is taken into rd
    task bus_xfer(input logic [31:0] addr, input logic wr, input logic [7:0] data);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, data};
        wait_ready();
        rd = hrdata;
    endtask

    // one-cycle event pulse, outputs judged the edge after
    task pulse(input int k, input logic deep, input logic [4:0] exp);
        @(posedge hclk);
        in_deepest_stop <= deep;
        case (k)
            0: stop_exec <= 1'b1;
            1: watchdog_expired <= 1'b1;
            2: temp_return_high <= 1'b1;
            default: temp_return_low <= 1'b1;
        endcase
        @(posedge hclk);
        stop_exec <= 1'b0;
        watchdog_expired <= 1'b0;
        temp_return_high <= 1'b0;
        temp_return_low <= 1'b0;
        #1;
        chk({27'h0, events}, {27'h0, exp});
    endtask

    task t_reset_values;
        bus_xfer(ADDR_FIRST, 1'b0, 8'h00);
        chk(rd, 32'h83);
        bus_xfer(ADDR_SECOND, 1'b0, 8'h00);
        chk(rd, 32'h70);
        chk({12'h0, watchdog_period}, 32'h80000);
        bus_xfer(32'h8, 1'b1, 8'hff);
        bus_xfer(32'h8, 1'b0, 8'h00);
        chk(rd, 32'h0);
        $display("test reset_values done");
    endtask

    task t_options;
        bus_xfer(ADDR_FIRST, 1'b1, 8'hec);
        bus_xfer(ADDR_FIRST, 1'b0, 8'h00);
        chk(rd, 32'hed);
        port_a_bit_four_data <= 1'b1;
        repeat (2) @(posedge hclk);
        #1;
        chk({30'h0, port_a_bit_four_oe, port_a_bit_four_out}, 32'h3);
        pulse(0, 1'b0, 5'b10000);
        pulse(1, 1'b0, 5'b00100);
        pulse(2, 1'b1, 5'b00001);
        pulse(2, 1'b0, 5'b00010);
        pulse(3, 1'b0, 5'b00000);
        bus_xfer(ADDR_FIRST, 1'b1, 8'h10);
        bus_xfer(ADDR_FIRST, 1'b0, 8'h00);
        chk(rd, 32'hf1);
        // mcu reset only: radio enable must survive it
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        bus_xfer(ADDR_FIRST, 1'b0, 8'h00);
        chk(rd, 32'h93);
        bus_xfer(ADDR_FIRST, 1'b1, 8'h02);
        bus_xfer(ADDR_FIRST, 1'b1, 8'he0);
        bus_xfer(ADDR_FIRST, 1'b0, 8'h00);
        chk(rd, 32'h01);
        pulse(0, 1'b0, 5'b01000);
        pulse(1, 1'b0, 5'b00000);
        $display("test options done");
    endtask

    task t_second;
        bus_xfer(ADDR_SECOND, 1'b1, 8'h8b);
        bus_xfer(ADDR_SECOND, 1'b0, 8'h00);
        chk(rd, 32'h0b);
        chk({12'h0, watchdog_period}, 32'h20);
        // timeout stays locked while bus select walks
        for (int c = 0; c < 4; c++) begin
            bus_xfer(ADDR_SECOND, 1'b1, 8'hf0 | 8'(c));
            bus_xfer(ADDR_SECOND, 1'b0, 8'h00);
            chk(rd, 32'(c));
            chk({high_freq_oscillator_khz, bus_clock_khz}, {16'h1f40 >> c, 16'h0fa0 >> c});
        end
        $display("test second done");
    endtask

    task t_timer;
        int n;
        logic prev;
        bus_xfer(ADDR_SECOND, 1'b1, 8'h00);
        port_a_bit_two_in <= 1'b1;
        low_freq_oscillator_in <= 1'b0;
        radio_clk_src <= 1'b1;
        repeat (2) @(posedge hclk);
        #1;
        chk({30'h0, timer_ch0_clk_src, timer_ch0_div_clk}, 32'h3);
        bus_xfer(ADDR_SECOND, 1'b1, 8'h0c);
        radio_clk_src <= 1'b0;
        repeat (4) @(posedge hclk);
        #1;
        chk({31'h0, timer_ch0_clk_src}, 32'h0);
        // 16 rising source edges give 4 toggles
        n = 0;
        prev = timer_ch0_div_clk;
        for (int i = 0; i < 68; i++) begin
            @(posedge hclk);
            radio_clk_src <= (i < 64) && !i[1];
            #1;
            if (timer_ch0_div_clk !== prev) begin
                n++;
            end
            prev = timer_ch0_div_clk;
        end
        chk(32'(n), 32'h4);
        $display("test timer done");
    endtask

    initial begin
        mismatches = 0;
        checks_done = 0;
        hresetn = 1'b0;
        por_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        {port_a_bit_four_data, port_a_bit_two_in, low_freq_oscillator_in, radio_clk_src} = 4'h0;
        {stop_exec, watchdog_expired, temp_return_low, temp_return_high, in_deepest_stop} = 5'h00;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        t_reset_values();
        t_options();
        t_second();
        t_timer();
        report_and_stop();
    end
endmodule
